// *** src/quad_out_pkg.sv ***
// Constants and types shared by the encoder quadrature pulse output block.
`default_nettype none

package quad_out_pkg;

   // ==========================================================================
   // Clock and pulse rate
   // ==========================================================================
   localparam longint CLK_HZ         = 250000000;
   localparam longint PULSE_MAX_HZ   = 1600000;
   localparam longint EDGE_MAX_HZ    = 4 * PULSE_MAX_HZ;
   // Least spacing between two output edges, rounded up to whole clocks.
   localparam int     EDGE_GAP_CYC   = int'((CLK_HZ + EDGE_MAX_HZ - 1) / EDGE_MAX_HZ);
   localparam int     GAP_W          = 8;
   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(EDGE_GAP_CYC - 1);

   // ==========================================================================
   // Pulse count setting
   // ==========================================================================
   localparam int           PPR_W       = 31;
   localparam logic [30:0]  PPR_MIN     = 31'h0000_0010;
   localparam logic [30:0]  PPR_DEFAULT = 31'h0000_0800;
   localparam logic [30:0]  PPR_LIM_1   = 31'h0000_4000;
   localparam logic [30:0]  PPR_LIM_2   = 31'h0000_8000;
   localparam logic [30:0]  PPR_LIM_4   = 31'h0001_0000;
   localparam logic [30:0]  PPR_LIM_8   = 31'h0002_0000;
   localparam logic [30:0]  PPR_LIM_16  = 31'h0004_0000;
   localparam logic [30:0]  PPR_MAX_13  = 31'h0000_0800;
   localparam logic [30:0]  PPR_MAX_17  = 31'h0000_8000;
   localparam logic [30:0]  PPR_MAX_20  = 31'h0004_0000;

   // ==========================================================================
   // Accumulator and position widths
   // ==========================================================================
   localparam int           ACC_W       = 21;
   localparam logic [20:0]  RES_13      = 21'h00_2000;
   localparam logic [20:0]  RES_17      = 21'h02_0000;
   localparam logic [20:0]  RES_20      = 21'h10_0000;
   localparam int           PEND_W      = 8;
   localparam logic [7:0]   PEND_MAX    = 8'h7F;
   localparam logic [7:0]   PEND_MIN    = 8'h81;

   // ==========================================================================
   // Speed limits in rpm
   // ==========================================================================
   localparam int           SPD_W       = 16;
   localparam logic [15:0]  SPD_LIM_1   = 16'h1770;
   localparam logic [15:0]  SPD_LIM_2   = 16'h0BB8;
   localparam logic [15:0]  SPD_LIM_4   = 16'h05DC;
   localparam logic [15:0]  SPD_LIM_8   = 16'h02EE;
   localparam logic [15:0]  SPD_LIM_16  = 16'h0177;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {
      RES_BITS_13 = 2'b00,
      RES_BITS_17 = 2'b01,
      RES_BITS_20 = 2'b10
   } enc_res_t;

   typedef struct packed {
      logic step;
      logic dir;
   } enc_move_t;

   typedef struct packed {
      logic [30:0] ppr;
      enc_res_t    res;
      logic        rev_sel;
   } quad_cfg_t;

endpackage

`default_nettype wire

// *** src/encoder_quadrature_pulse_output.sv ***
// Divided quadrature A/B and index pulse output with setting and overspeed alarms.
// Notes on behaviour
// - A and B quadrature, count equals setting
// - Every phase has a complementary output
// - Index pulses exactly once per revolution
// - Index width equals one A pulse
// - Reverse mode keeps the same phase form
// - Divide encoder count, latched at restart
// - Setting must meet step per range
// - Maximum setting depends on encoder resolution
// - Bad setting raises setting alarm
// - Speed above range limit raises overspeed alarm
// - Output pulse rate stays below 1.6 Mpps
`timescale 1ns/1ps
`default_nettype none

module encoder_quadrature_pulse_output
   import quad_out_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Encoder motion, one step per encoder count, in command direction
   input  wire enc_move_t   enc_move,
   // Setup, sampled once after reset release
   input  wire quad_cfg_t   cfg,
   // Motor speed magnitude in rpm
   input  wire logic [15:0] motor_speed_rpm,
   // Pulse outputs
   output logic             quad_a_out,
   output logic             quad_a_out_n,
   output logic             quad_b_out,
   output logic             quad_b_out_n,
   output logic             index_out,
   output logic             index_out_n,
   // Alarms
   output logic             alarm_setting,
   output logic             alarm_overspeed
);

   // ==========================================================================
   // Setting decode
   // ==========================================================================
   function automatic logic ppr_ok(input logic [30:0] p, input enc_res_t r);
      logic [30:0] mx;
      logic        step_ok;
      mx = PPR_MAX_13;
      unique case (r)
         RES_BITS_13: mx = PPR_MAX_13;
         RES_BITS_17: mx = PPR_MAX_17;
         RES_BITS_20: mx = PPR_MAX_20;
         default:     mx = '0;
      endcase
      if (p <= PPR_LIM_1) begin
         step_ok = 1'b1;
      end else if (p <= PPR_LIM_2) begin
         step_ok = (p[0] == 1'b0);
      end else if (p <= PPR_LIM_4) begin
         step_ok = (p[1:0] == 2'h0);
      end else if (p <= PPR_LIM_8) begin
         step_ok = (p[2:0] == 3'h0);
      end else begin
         step_ok = (p[3:0] == 4'h0);
      end
      return (p >= PPR_MIN) && (p <= mx) && step_ok;
   endfunction

   function automatic logic [15:0] speed_limit(input logic [30:0] p);
      if (p <= PPR_LIM_1) begin
         return SPD_LIM_1;
      end else if (p <= PPR_LIM_2) begin
         return SPD_LIM_2;
      end else if (p <= PPR_LIM_4) begin
         return SPD_LIM_4;
      end else if (p <= PPR_LIM_8) begin
         return SPD_LIM_8;
      end
      return SPD_LIM_16;
   endfunction

   function automatic logic [20:0] res_count(input enc_res_t r);
      unique case (r)
         RES_BITS_13: return RES_13;
         RES_BITS_17: return RES_17;
         RES_BITS_20: return RES_20;
         default:     return RES_20;
      endcase
   endfunction

   // ==========================================================================
   // Setting capture after restart
   // ==========================================================================
   // Changing the setting while running would break the revolution count,
   // so it is taken once after reset and held until the next reset.
   logic        loaded_r;
   logic        cfg_ok_r;
   logic        rev_sel_r;
   logic [30:0] ppr_r;
   logic [20:0] res_r;
   logic [20:0] quarter_inc_r;
   logic [20:0] rev_quarters_r;
   logic [15:0] spd_lim_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         loaded_r       <= 1'b0;
         cfg_ok_r       <= 1'b0;
         rev_sel_r      <= 1'b0;
         ppr_r          <= PPR_DEFAULT;
         res_r          <= RES_20;
         quarter_inc_r  <= '0;
         rev_quarters_r <= '0;
         spd_lim_r      <= SPD_LIM_1;
      end else if (!loaded_r) begin
         loaded_r       <= 1'b1;
         cfg_ok_r       <= ppr_ok(cfg.ppr, cfg.res);
         rev_sel_r      <= cfg.rev_sel;
         ppr_r          <= cfg.ppr;
         res_r          <= res_count(cfg.res);
         quarter_inc_r  <= {cfg.ppr[18:0], 2'b00};
         rev_quarters_r <= {cfg.ppr[18:0], 2'b00};
         spd_lim_r      <= speed_limit(cfg.ppr);
      end
   end

   logic running;
   assign running = loaded_r && cfg_ok_r;

   // ==========================================================================
   // Alarms
   // ==========================================================================
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_setting <= 1'b0;
      end else if (loaded_r && !cfg_ok_r) begin
         alarm_setting <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alarm_overspeed <= 1'b0;
      end else if (running && (motor_speed_rpm > spd_lim_r)) begin
         alarm_overspeed <= 1'b1;
      end
   end

   // ==========================================================================
   // Division of encoder counts into quarter steps
   // ==========================================================================
   // The incoming direction is in command sense; undoing the direction
   // select restores motor sense so reverse mode shows the same phase form.
   logic motor_fwd;
   assign motor_fwd = enc_move.dir ^ rev_sel_r;

   logic [20:0] acc_r;
   logic        q_up;
   logic        q_dn;
   logic [20:0] acc_sum;
   logic [20:0] acc_nxt;

   always_comb begin
      q_up    = 1'b0;
      q_dn    = 1'b0;
      acc_sum = acc_r + quarter_inc_r;
      acc_nxt = acc_r;
      if (running && enc_move.step) begin
         if (motor_fwd) begin
            if (acc_sum >= res_r) begin
               acc_nxt = acc_sum - res_r;
               q_up    = 1'b1;
            end else begin
               acc_nxt = acc_sum;
            end
         end else if (acc_r < quarter_inc_r) begin
            acc_nxt = acc_r + res_r - quarter_inc_r;
            q_dn    = 1'b1;
         end else begin
            acc_nxt = acc_r - quarter_inc_r;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // ==========================================================================
   // Edge rate limiter
   // ==========================================================================
   // Quarter steps owed to the output are banked, then paid out no faster
   // than the rate ceiling; a burst beyond the bank depth is clipped.
   logic [7:0]  pend_r;
   logic [7:0]  gap_r;
   logic        gap_done;
   logic        emit;
   logic        emit_up;
   logic [7:0]  pend_nxt;

   assign gap_done = (gap_r == GAP_LAST);
   assign emit     = gap_done && (pend_r != '0);
   assign emit_up  = !pend_r[7];

   always_comb begin
      pend_nxt = pend_r;
      if (emit) begin
         pend_nxt = emit_up ? pend_r - 8'h01 : pend_r + 8'h01;
      end
      if (q_up && (pend_nxt != PEND_MAX)) begin
         pend_nxt = pend_nxt + 8'h01;
      end else if (q_dn && (pend_nxt != PEND_MIN)) begin
         pend_nxt = pend_nxt - 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend_r <= '0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gap_r <= '0;
      end else if (emit) begin
         gap_r <= '0;
      end else if (!gap_done) begin
         gap_r <= gap_r + 8'h01;
      end
   end

   // ==========================================================================
   // Output position within one revolution
   // ==========================================================================
   // Exactly four times the setting quarter steps make a turn, so the
   // position wraps once per revolution whatever the setting is.
   logic [20:0] pos_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pos_r <= '0;
      end else if (emit && emit_up) begin
         pos_r <= (pos_r == rev_quarters_r - 21'h00_0001) ? '0 : pos_r + 21'h00_0001;
      end else if (emit) begin
         pos_r <= (pos_r == '0) ? rev_quarters_r - 21'h00_0001 : pos_r - 21'h00_0001;
      end
   end

   // ==========================================================================
   // Pin drivers
   // ==========================================================================
   // Gray order of (A,B) by quarter: 00, 10, 11, 01, so A leads going up.
   logic [20:0] pos_nxt;
   logic        a_nxt;
   logic        b_nxt;
   logic        c_nxt;

   always_comb begin
      pos_nxt = pos_r;
      if (emit && emit_up) begin
         pos_nxt = (pos_r == rev_quarters_r - 21'h00_0001) ? '0 : pos_r + 21'h00_0001;
      end else if (emit) begin
         pos_nxt = (pos_r == '0) ? rev_quarters_r - 21'h00_0001 : pos_r - 21'h00_0001;
      end
      a_nxt = pos_nxt[1] ^ pos_nxt[0];
      b_nxt = pos_nxt[1];
      c_nxt = running && (pos_nxt[20:2] == '0) && a_nxt;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         quad_a_out   <= 1'b0;
         quad_a_out_n <= 1'b1;
         quad_b_out   <= 1'b0;
         quad_b_out_n <= 1'b1;
         index_out    <= 1'b0;
         index_out_n  <= 1'b1;
      end else begin
         quad_a_out   <= a_nxt;
         quad_a_out_n <= !a_nxt;
         quad_b_out   <= b_nxt;
         quad_b_out_n <= !b_nxt;
         index_out    <= c_nxt;
         index_out_n  <= !c_nxt;
      end
   end

   // The host relies on slow or repeated turns when homing on the index,
   // since the rate limiter may delay the index edge at high speed.

endmodule

`default_nettype wire

// *** bench/quad_out_chk.sv ***
// Assertion checker for the quadrature pulse output block.
`timescale 1ns/1ps
`default_nettype none

module quad_out_chk
   import quad_out_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Inputs
   input  wire quad_cfg_t   cfg,
   input  wire logic [15:0] motor_speed_rpm,
   // Pulse outputs
   input  wire logic        quad_a_out,
   input  wire logic        quad_a_out_n,
   input  wire logic        quad_b_out,
   input  wire logic        quad_b_out_n,
   input  wire logic        index_out,
   input  wire logic        index_out_n,
   // Alarms
   input  wire logic        alarm_setting,
   input  wire logic        alarm_overspeed
);
   // ==========================================================================
   // Helper logic
   // ==========================================================================
   logic [7:0]  gap_r;
   logic [15:0] lim_w;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Starts saturated so the first edge after reset is never judged too early.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gap_r <= 8'hFF;
      end else if ($changed(quad_a_out) || $changed(quad_b_out)) begin
         gap_r <= 8'h00;
      end else if (gap_r != 8'hFF) begin
         gap_r <= gap_r + 8'h01;
      end
   end

   assign lim_w = cfg.ppr <= PPR_LIM_1 ? SPD_LIM_1 : cfg.ppr <= PPR_LIM_2 ? SPD_LIM_2 :
                  cfg.ppr <= PPR_LIM_4 ? SPD_LIM_4 : cfg.ppr <= PPR_LIM_8 ? SPD_LIM_8 : SPD_LIM_16;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_pair_a: assert property (quad_a_out_n != quad_a_out)
      else $error("phase A pair not complementary");
   a_pair_b: assert property (quad_b_out_n != quad_b_out)
      else $error("phase B pair not complementary");
   a_pair_index: assert property (index_out_n != index_out)
      else $error("index pair not complementary");
   a_one_phase: assert property (!($changed(quad_a_out) && $changed(quad_b_out)))
      else $error("A and B moved together");
   a_edge_gap: assert property (($changed(quad_a_out) || $changed(quad_b_out)) |-> gap_r >= GAP_LAST)
      else $error("output edges too close");
   a_index_rise: assert property ($rose(index_out) |-> $rose(quad_a_out))
      else $error("index rose without A");
   a_index_fall: assert property ($fell(index_out) |-> $fell(quad_a_out))
      else $error("index fell without A");
   a_index_in_a: assert property (index_out |-> quad_a_out)
      else $error("index high outside A high");
   a_setting_sticky: assert property (alarm_setting |=> alarm_setting)
      else $error("setting alarm dropped");
   a_setting_frozen: assert property (alarm_setting |=> $stable(quad_a_out) && $stable(quad_b_out))
      else $error("outputs moved under setting alarm");
   a_speed_sticky: assert property (alarm_overspeed |=> alarm_overspeed)
      else $error("overspeed alarm dropped");
   a_speed_limit: assert property ((!alarm_setting && motor_speed_rpm > lim_w) ##2 !alarm_setting |-> ##[0:1] alarm_overspeed)
      else $error("overspeed not flagged");
endmodule

bind encoder_quadrature_pulse_output quad_out_chk i_quad_out_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .motor_speed_rpm(motor_speed_rpm),
   .quad_a_out(quad_a_out), .quad_a_out_n(quad_a_out_n), .quad_b_out(quad_b_out), .quad_b_out_n(quad_b_out_n),
   .index_out(index_out), .index_out_n(index_out_n), .alarm_setting(alarm_setting),
   .alarm_overspeed(alarm_overspeed));

`default_nettype wire

// *** bench/quad_host_model.sv ***
// Host controller model that decodes the pulse lines into position and index counts.
`timescale 1ns/1ps
`default_nettype none

module quad_host_model (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Pulse lines
   input  wire logic          a,
   input  wire logic          a_n,
   input  wire logic          b,
   input  wire logic          b_n,
   input  wire logic          c,
   input  wire logic          c_n,
   // Decoded results
   output logic signed [31:0] pos,
   output logic [31:0]        idx_cnt,
   output logic               err
);
   logic [1:0] g_r;
   logic [1:0] g_w;
   logic       c_r;

   assign g_w = {a, b} == 2'h0 ? 2'h0 : {a, b} == 2'h2 ? 2'h1 : {a, b} == 2'h3 ? 2'h2 : 2'h3;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         g_r <= 2'h0;
         c_r <= 1'b0;
         pos <= 32'sh0;
         idx_cnt <= 32'h0;
         err <= 1'b0;
      end else begin
         g_r <= g_w;
         c_r <= c;
         if (g_w - g_r == 2'h1) begin
            pos <= pos + 32'sh1;
         end
         if (g_w - g_r == 2'h3) begin
            pos <= pos - 32'sh1;
         end
         // A two-quarter jump cannot be decoded, so it is an error.
         if (g_w - g_r == 2'h2 || a_n == a || b_n == b || c_n == c) begin
            err <= 1'b1;
         end
         // Every rising edge of the index line adds one to the index count.
         if (c && !c_r) begin
            idx_cnt <= idx_cnt + 32'h1;
         end
      end
   end
endmodule

`default_nettype wire

// *** bench/encoder_quadrature_pulse_output_tb.sv ***
// Self-checking testbench for the quadrature pulse output block.
`timescale 1ns/1ps
`default_nettype none

module encoder_quadrature_pulse_output_tb;
   import quad_out_pkg::*;

   localparam logic [30:0] SET_PPR [13] = '{31'h10, 31'hF, 31'h801, 31'h4000, 31'h4001, 31'h8002, 31'h61A8,
                                            31'h61A9, 31'h10004, 31'h10006, 31'h40010, 31'h10, 31'h40000};
   localparam logic [12:0] SET_BAD = 13'h0FB6;

   logic               sys_clk;
   logic               rst_n;
   enc_move_t          enc_move;
   quad_cfg_t          cfg;
   logic [15:0]        motor_speed_rpm;
   logic               qa;
   logic               qa_n;
   logic               qb;
   logic               qb_n;
   logic               qc;
   logic               qc_n;
   logic               alarm_setting;
   logic               alarm_overspeed;
   logic signed [31:0] pos;
   logic [31:0]        idx_cnt;
   logic               err;
   int                 miscompares;
   int                 compares;

   encoder_quadrature_pulse_output i_encoder_quadrature_pulse_output (
      .sys_clk(sys_clk), .rst_n(rst_n), .enc_move(enc_move), .cfg(cfg), .motor_speed_rpm(motor_speed_rpm),
      .quad_a_out(qa), .quad_a_out_n(qa_n), .quad_b_out(qb), .quad_b_out_n(qb_n), .index_out(qc),
      .index_out_n(qc_n), .alarm_setting(alarm_setting), .alarm_overspeed(alarm_overspeed));

   quad_host_model i_quad_host_model (
      .clk(sys_clk), .rst_n(rst_n), .a(qa), .a_n(qa_n), .b(qb), .b_n(qb_n), .c(qc), .c_n(qc_n),
      .pos(pos), .idx_cnt(idx_cnt), .err(err));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   task automatic restart(input logic [30:0] ppr, input logic [1:0] res, input logic rs, input logic [15:0] spd);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      cfg <= '{ppr: ppr, res: enc_res_t'(res), rev_sel: rs};
      motor_speed_rpm <= spd;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask

   // Steps every clock; the 200-clock tail wait lets up to five banked quarters leave the limiter.
   task automatic turn(input int n, input logic d);
      repeat (n) begin
         @(posedge sys_clk);
         enc_move <= '{step: 1'b1, dir: d};
      end
      @(posedge sys_clk);
      enc_move <= '0;
      repeat (200) @(posedge sys_clk);
   endtask

   task automatic sc_turns;
      restart(31'h10, 2'h0, 1'b0, 16'h0);
      cfg.ppr <= 31'hF;
      turn(16384, 1'b1);
      chk("pos", 32'h80, pos);
      chk("index", 32'h2, idx_cnt);
      turn(8192, 1'b0);
      chk("pos", 32'h40, pos);
      chk("index", 32'h3, idx_cnt);
      chk("alarms", 32'h0, 32'({alarm_setting, alarm_overspeed, err}));
   endtask

   task automatic sc_rev;
      restart(31'h10, 2'h0, 1'b1, 16'h0);
      turn(8192, 1'b0);
      chk("pos", 32'h40, pos);
      chk("index", 32'h1, idx_cnt);
   endtask

   task automatic sc_setting;
      for (int i = 0; i < 13; i++) begin
         restart(SET_PPR[i], i < 3 ? 2'h0 : i < 6 ? 2'h1 : i == 11 ? 2'h3 : 2'h2, 1'b0, 16'h0);
         turn(64, 1'b1);
         chk("setting", 32'(SET_BAD[i]), 32'(alarm_setting));
         if (SET_BAD[i]) begin
            chk("pos", 32'h0, pos);
         end
      end
   endtask

   task automatic sc_speed(input logic [30:0] ppr, input logic [1:0] res, input logic [15:0] lim);
      restart(ppr, res, 1'b0, lim);
      chk("alarms", 32'h0, 32'({alarm_setting, alarm_overspeed}));
      motor_speed_rpm <= lim + 16'h1;
      repeat (3) @(posedge sys_clk);
      chk("overspeed", 32'h1, 32'(alarm_overspeed));
   endtask

   task automatic results;
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      enc_move = '0;
      cfg = '{ppr: PPR_DEFAULT, res: RES_BITS_13, rev_sel: 1'b0};
      motor_speed_rpm = 16'h0;
      miscompares = 0;
      compares = 0;
      sc_turns;
      sc_rev;
      sc_setting;
      sc_speed(PPR_LIM_1, 2'h1, SPD_LIM_1);
      sc_speed(PPR_LIM_2, 2'h1, SPD_LIM_2);
      sc_speed(PPR_LIM_4, 2'h2, SPD_LIM_4);
      sc_speed(PPR_LIM_8, 2'h2, SPD_LIM_8);
      sc_speed(PPR_LIM_16, 2'h2, SPD_LIM_16);
      results;
   end
endmodule

`default_nettype wire
